// ### hw/tw_pkg.sv
// Shared constants and types of the thermal watchdog and its serial target.
// Assumes one 125 MHz clock domain; the bus pins are synchronised before use.
package tw_pkg;

    // Register pointer values.
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CONF = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_TOS  = 2'h3;
    localparam logic [1:0] PTR_RST  = 2'h0;

    // Configuration byte fields and values after reset.
    localparam int         CONF_SHDN = 0;
    localparam int         CONF_MODE = 1;
    localparam int         CONF_POL  = 2;
    localparam int         CONF_QLO  = 3;
    localparam logic [7:0] CONF_RST  = 8'h00;

    // Set-points in half-degree steps: 80 C and 75 C.
    localparam logic [8:0] TOS_RST  = 9'h0A0;
    localparam logic [8:0] HYST_RST = 9'h096;

    // Consecutive-trip counts per queue selection.
    localparam logic [2:0] QUEUE_0 = 3'h1;
    localparam logic [2:0] QUEUE_1 = 3'h2;
    localparam logic [2:0] QUEUE_2 = 3'h4;
    localparam logic [2:0] QUEUE_3 = 3'h6;

    // Data byte indices within a transfer.
    localparam logic [1:0] IDX_PTR = 2'h0;
    localparam logic [1:0] IDX_MSB = 2'h1;
    localparam logic [1:0] IDX_LSB = 2'h2;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_WR   = 7'h08,
        S_WACK = 7'h10,
        S_RD   = 7'h20,
        S_RACK = 7'h40
    } tw_bus_state_t;

    // Byte events handed from the serial target to the register file.
    typedef struct packed {
        logic       wr_stb;
        logic [1:0] wr_idx;
        logic [7:0] wr_data;
        logic       rd_stb;
        logic [1:0] rd_idx;
    } tw_bus_ev_t;

endpackage

// ### hw/tw_fault_queue.sv
// Consecutive-trip counter that fires once the selected count is reached.
// Assumes sample_in is a one-cycle pulse per finished conversion.
`timescale 1ns/10ps
module tw_fault_queue #(
    parameter int W = 3
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sample_in,
    input  wire logic       trip_in,
    input  wire logic       clear_in,
    input  wire logic [1:0] sel_in,
    output logic            fire_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tw_fq_state_t;

    tw_fq_state_t r_reg;
    tw_fq_state_t r_next;
    logic [W-1:0] target;

    always_comb begin
        case (sel_in)
            2'h0:    target = W'(tw_pkg::QUEUE_0);
            2'h1:    target = W'(tw_pkg::QUEUE_1);
            2'h2:    target = W'(tw_pkg::QUEUE_2);
            default: target = W'(tw_pkg::QUEUE_3);
        endcase
        fire_out = sample_in && trip_in && (r_reg.cnt + W'(1) >= target);
        r_next   = r_reg;
        if (clear_in || fire_out || (sample_in && !trip_in)) begin
            r_next.cnt = '0;
        end else if (sample_in) begin
            r_next.cnt = r_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule // tw_fault_queue

// ### hw/tw_i2c_target.sv
// Serial bus target: start/stop detection, address match, byte shifting.
// Assumes the host supplies the bus clock, well below a quarter of mclk.
`timescale 1ns/10ps
module tw_i2c_target #(
    parameter logic [6:0] ADDR = 7'h48
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic [7:0]  rd_data_in,
    output logic             sda_oe_out,
    output tw_pkg::tw_bus_ev_t ev_out
);
    typedef struct packed {
        logic [1:0]            scl_s;
        logic [1:0]            sda_s;
        logic                  scl_q;
        logic                  sda_q;
        tw_pkg::tw_bus_state_t st;
        logic [3:0]            cnt;
        logic [7:0]            sh;
        logic                  rw;
        logic                  acked;
        logic                  oe;
        logic [1:0]            widx;
        logic [1:0]            ridx;
        logic                  wr_stb;
        logic                  rd_stb;
    } tw_bus_reg_t;

    tw_bus_reg_t r_reg;
    tw_bus_reg_t r_next;
    logic        scl;
    logic        sda;
    logic        rise;
    logic        fall;

    always_comb begin
        r_next        = r_reg;
        r_next.wr_stb = 1'b0;
        r_next.rd_stb = 1'b0;
        r_next.scl_s  = {r_reg.scl_s[0], scl_in};
        r_next.sda_s  = {r_reg.sda_s[0], sda_in};
        r_next.scl_q  = r_reg.scl_s[1];
        r_next.sda_q  = r_reg.sda_s[1];
        scl  = r_reg.scl_s[1];
        sda  = r_reg.sda_s[1];
        rise = scl && !r_reg.scl_q;
        fall = !scl && r_reg.scl_q;
        if (scl && r_reg.scl_q && r_reg.sda_q && !sda) begin
            r_next.st  = tw_pkg::S_ADDR;
            r_next.cnt = 4'h0;
            r_next.oe  = 1'b0;
        end else if (scl && r_reg.scl_q && !r_reg.sda_q && sda) begin
            r_next.st = tw_pkg::S_IDLE;
            r_next.oe = 1'b0;
        end else begin
            case (r_reg.st)
                // eight bits then one acknowledge slot.
                tw_pkg::S_ADDR, tw_pkg::S_WR: begin
                    if (rise) begin
                        r_next.sh  = {r_reg.sh[6:0], sda};
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end else if (fall && r_reg.cnt == 4'h8) begin
                        if (r_reg.st == tw_pkg::S_WR) begin
                            r_next.st     = tw_pkg::S_WACK;
                            r_next.oe     = 1'b1;
                            r_next.wr_stb = 1'b1;
                        end else if (r_reg.sh[7:1] == ADDR) begin
                            r_next.st   = tw_pkg::S_AACK;
                            r_next.oe   = 1'b1;
                            r_next.rw   = r_reg.sh[0];
                            r_next.widx = 2'h0;
                            r_next.ridx = 2'h0;
                        end else begin
                            r_next.st = tw_pkg::S_IDLE;
                        end
                    end
                end
                tw_pkg::S_AACK: begin
                    if (fall) begin
                        r_next.cnt = 4'h0;
                        if (r_reg.rw) begin
                            r_next.st     = tw_pkg::S_RD;
                            r_next.sh     = rd_data_in;
                            r_next.rd_stb = 1'b1;
                            r_next.oe     = !rd_data_in[7];
                        end else begin
                            r_next.st = tw_pkg::S_WR;
                            r_next.oe = 1'b0;
                        end
                    end
                end
                tw_pkg::S_WACK: begin
                    if (fall) begin
                        r_next.st   = tw_pkg::S_WR;
                        r_next.oe   = 1'b0;
                        r_next.cnt  = 4'h0;
                        r_next.widx = r_reg.widx + {1'b0, r_reg.widx != 2'h3};
                    end
                end
                tw_pkg::S_RD: begin
                    if (rise) begin
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end else if (fall) begin
                        if (r_reg.cnt == 4'h8) begin
                            r_next.st = tw_pkg::S_RACK;
                            r_next.oe = 1'b0;
                        end else begin
                            r_next.sh = {r_reg.sh[6:0], 1'b0};
                            r_next.oe = !r_reg.sh[6];
                        end
                    end
                end
                tw_pkg::S_RACK: begin
                    if (rise) begin
                        // host low here asks for the next byte.
                        r_next.acked = !sda;
                        r_next.ridx  = r_reg.ridx + {1'b0, !sda && r_reg.ridx != 2'h3};
                    end else if (fall) begin
                        // a released slot ends the read.
                        if (r_reg.acked) begin
                            r_next.st     = tw_pkg::S_RD;
                            r_next.cnt    = 4'h0;
                            r_next.sh     = rd_data_in;
                            r_next.rd_stb = 1'b1;
                            r_next.oe     = !rd_data_in[7];
                        end else begin
                            r_next.st = tw_pkg::S_IDLE;
                        end
                    end
                end
                default: begin
                    r_next.st = tw_pkg::S_IDLE;
                    r_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg       <= '0;
            r_reg.st    <= tw_pkg::S_IDLE;
            // Idle bus is high; starting the detectors there avoids a false edge.
            r_reg.scl_s <= 2'h3;
            r_reg.sda_s <= 2'h3;
            r_reg.scl_q <= 1'b1;
            r_reg.sda_q <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sda_oe_out = r_reg.oe;
    assign ev_out     = '{wr_stb: r_reg.wr_stb, wr_idx: r_reg.widx, wr_data: r_reg.sh,
                          rd_stb: r_reg.rd_stb, rd_idx: r_reg.ridx};
endmodule // tw_i2c_target

// ### hw/tw_thermal_watchdog.sv
// Thermal watchdog: register file, set-point compare and open-drain alert.
// Assumes conv_done_in pulses for one mclk cycle with temp_data_in valid,
// and that scl_in and sda_in come straight from the pins.
//
// How it works
// - Compare the set-point picked by the armed side after every conversion.
// - Set-points are 9-bit, half-degree two's complement.
// - Compare only the top 9 temperature bits.
// - Set-point reads give 16 bits, low seven zero.
// - Config bit 2 selects alert level, reset low.
// - Config bit 1 selects interrupt, reset comparator.
// - Comparator alert follows thresholds; reads leave it.
// - Interrupt alert holds until any register read.
// - Alert needs 1, 2, 4 or 6 trips.
// - Config bit 0 enters or leaves shutdown.
// - Shutdown stops conversions; bus stays alive.
// - Shutdown keeps comparator alert, clears interrupt.
// - Reset gives 80 C, 75 C, pointer zero.
// - Single-byte temperature read ends cleanly.
// - Each byte is eight bits plus acknowledge.
// - Device pulls acknowledge low after host bytes.
// - Host acknowledge requests the second read byte.
// - Final read slot left released by both.
// - Pointer's low two bits pick the register.
// - Writes start with pointer; reads reuse it.
// - Temperature is 11 bits, low five zero.
`timescale 1ns/10ps
module tw_thermal_watchdog #(
    parameter logic [6:0] ADDR = 7'h48
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        conv_done_in,
    input  wire logic [10:0] temp_data_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    output logic             alert_out,
    output logic             alert_oe_out,
    output logic             conv_enable_out
);
    typedef struct packed {
        logic [1:0]  ptr;
        logic [7:0]  conf;
        logic [8:0]  tos;
        logic [8:0]  hyst;
        logic [10:0] temp;
        logic        side;
        logic        pend;
        logic        aoe;
        logic        conv_en;
    } tw_wd_state_t;

    tw_wd_state_t       r_reg;
    tw_wd_state_t       r_next;
    tw_pkg::tw_bus_ev_t ev;
    logic [7:0]         rd_byte;
    logic               sample;
    logic               trip;
    logic               over;
    logic               under;
    logic               fire;
    logic               int_mode;
    logic               active;
    logic               conf_wr;
    logic               sd_set;

    ////////////////////////////////////////////////////////////////////////////////
    tw_i2c_target #(
        .ADDR (ADDR)
    ) u_bus (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .rd_data_in (rd_byte),
        .sda_oe_out (sda_oe_out),
        .ev_out     (ev)
    );

    tw_fault_queue #(
        .W (3)
    ) u_queue (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .sample_in (sample),
        .trip_in   (trip),
        .clear_in  (conf_wr),
        .sel_in    (r_reg.conf[tw_pkg::CONF_QLO +: 2]),
        .fire_out  (fire)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read byte chosen by the latched pointer and the byte index.
    always_comb begin
        rd_byte = 8'h00;
        case (r_reg.ptr)
            // result in top 11 bits, rest zero.
            tw_pkg::PTR_TEMP: begin
                if (ev.rd_idx == tw_pkg::IDX_PTR) begin
                    rd_byte = r_reg.temp[10:3];
                end else if (ev.rd_idx == tw_pkg::IDX_MSB) begin
                    rd_byte = {r_reg.temp[2:0], 5'h00};
                end
            end
            tw_pkg::PTR_CONF: begin
                if (ev.rd_idx == tw_pkg::IDX_PTR) begin
                    rd_byte = r_reg.conf;
                end
            end
            // second byte carries one bit, seven zeros.
            tw_pkg::PTR_HYST: begin
                if (ev.rd_idx == tw_pkg::IDX_PTR) begin
                    rd_byte = r_reg.hyst[8:1];
                end else if (ev.rd_idx == tw_pkg::IDX_MSB) begin
                    rd_byte = {r_reg.hyst[0], 7'h00};
                end
            end
            default: begin
                if (ev.rd_idx == tw_pkg::IDX_PTR) begin
                    rd_byte = r_reg.tos[8:1];
                end else if (ev.rd_idx == tw_pkg::IDX_MSB) begin
                    rd_byte = {r_reg.tos[0], 7'h00};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        int_mode = r_reg.conf[tw_pkg::CONF_MODE];
        conf_wr  = ev.wr_stb && ev.wr_idx == tw_pkg::IDX_MSB && r_reg.ptr == tw_pkg::PTR_CONF;
        sd_set   = conf_wr && ev.wr_data[tw_pkg::CONF_SHDN] && !r_reg.conf[tw_pkg::CONF_SHDN];
        // no conversion is taken while shut down.
        sample   = conv_done_in && !r_reg.conf[tw_pkg::CONF_SHDN];
        // only the nine top result bits count.
        over     = $signed(temp_data_in[10:2]) > $signed(r_reg.tos);
        under    = $signed(temp_data_in[10:2]) < $signed(r_reg.hyst);
        // the armed side decides which crossing trips.
        trip     = r_reg.side ? under : over;
        r_next   = r_reg;
        r_next.conv_en = !r_reg.conf[tw_pkg::CONF_SHDN];
        // first written byte is the pointer.
        if (ev.wr_stb) begin
            case (ev.wr_idx)
                tw_pkg::IDX_PTR: r_next.ptr = ev.wr_data[1:0];
                // the byte after the pointer holds set-point bits 8..1, or the whole config byte.
                tw_pkg::IDX_MSB: begin
                    case (r_reg.ptr)
                        // writing the shutdown bit enters or leaves shutdown.
                        tw_pkg::PTR_CONF: r_next.conf = ev.wr_data;
                        tw_pkg::PTR_HYST: r_next.hyst[8:1] = ev.wr_data;
                        tw_pkg::PTR_TOS:  r_next.tos[8:1] = ev.wr_data;
                        default:          r_next.ptr = r_reg.ptr;
                    endcase
                end
                tw_pkg::IDX_LSB: begin
                    if (r_reg.ptr == tw_pkg::PTR_HYST) begin
                        r_next.hyst[0] = ev.wr_data[7];
                    end else if (r_reg.ptr == tw_pkg::PTR_TOS) begin
                        r_next.tos[0] = ev.wr_data[7];
                    end
                end
                default: r_next.ptr = r_reg.ptr;
            endcase
        end
        // any read clears a pending interrupt.
        if (ev.rd_stb) begin
            r_next.pend = 1'b0;
        end
        // entering shutdown clears a pending interrupt only.
        if (sd_set && int_mode) begin
            r_next.pend = 1'b0;
        end
        // every taken conversion updates the result and feeds the fault queue.
        if (sample) begin
            r_next.temp = temp_data_in;
        end
        // the queue decides when enough trips have passed.
        if (fire) begin
            // comparator state flips on a qualified crossing.
            r_next.side = !r_reg.side;
            // interrupt mode latches the event until read.
            if (int_mode) begin
                r_next.pend = 1'b1;
            end
        end
        active = int_mode ? r_reg.pend : r_reg.side;
        // drive the pin low when the active level is low.
        r_next.aoe = r_reg.conf[tw_pkg::CONF_POL] ? !active : active;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg         <= '0;
            r_reg.ptr     <= tw_pkg::PTR_RST;
            r_reg.conf    <= tw_pkg::CONF_RST;
            r_reg.tos     <= tw_pkg::TOS_RST;
            r_reg.hyst    <= tw_pkg::HYST_RST;
            r_reg.conv_en <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // a single-byte read ends like any other read, in the bus target.
    assign sda_out         = 1'b0;
    assign alert_out       = 1'b0;
    assign alert_oe_out    = r_reg.aoe;
    assign conv_enable_out = r_reg.conv_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks kept beside the logic they guard.
    property p_ptr_latch;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ev.wr_stb && ev.wr_idx == tw_pkg::IDX_PTR |=> r_reg.ptr == $past(ev.wr_data[1:0]);
    endproperty
    a_ptr_latch: assert property (p_ptr_latch)
        else $error("pointer byte not latched");

    property p_pol;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> alert_oe_out == ($past(r_reg.conf[tw_pkg::CONF_POL]) ^ $past(active));
    endproperty
    a_pol: assert property (p_pol)
        else $error("alert level does not follow polarity");

    property p_int_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ev.rd_stb && !fire |=> !r_reg.pend;
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("read did not clear pending alert");

    property p_int_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        r_reg.pend && !ev.rd_stb && !ev.wr_stb |=> r_reg.pend;
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("pending alert dropped without a read");

    property p_sd_int;
        @(posedge mclk_in) disable iff (!rst_n_in)
        sd_set && int_mode && ev.wr_data[tw_pkg::CONF_MODE] && !fire
        |=> !r_reg.pend ##1 alert_oe_out == r_reg.conf[tw_pkg::CONF_POL];
    endproperty
    a_sd_int: assert property (p_sd_int)
        else $error("shutdown did not clear interrupt alert");

    property p_cmp_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !fire |=> $stable(r_reg.side);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("comparator state moved without a trip");

    property p_noconv;
        @(posedge mclk_in) disable iff (!rst_n_in)
        r_reg.conf[tw_pkg::CONF_SHDN] && conv_done_in |=> $stable(r_reg.temp) && !conv_enable_out;
    endproperty
    a_noconv: assert property (p_noconv)
        else $error("conversion taken in shutdown");

    property p_fire1;
        @(posedge mclk_in) disable iff (!rst_n_in)
        sample && r_reg.conf[tw_pkg::CONF_QLO +: 2] == 2'h0 && !r_reg.side && over
        |=> r_reg.side;
    endproperty
    a_fire1: assert property (p_fire1)
        else $error("single trip did not raise alert");

    property p_thr_lsb;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ev.rd_idx == tw_pkg::IDX_MSB && r_reg.ptr[1] |-> rd_byte[6:0] == 7'h00;
    endproperty
    a_thr_lsb: assert property (p_thr_lsb)
        else $error("set-point low bits not zero");

    c_two_byte: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        ev.rd_stb && ev.rd_idx == tw_pkg::IDX_MSB);
    c_int_fire: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        fire && int_mode);
    c_sd_set: cover property (@(posedge mclk_in) disable iff (!rst_n_in) sd_set);
endmodule // tw_thermal_watchdog

// ### bench/tw_host_model.sv
// Bus host model: makes the serial clock and pulls the data line low.
// Assumes the bench resolves the data wire from both pull-down enables.
`timescale 1ns/10ps
module tw_host_model (
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Half of an 80 ns bus clock period.
    task automatic hp;
        repeat (5) @(posedge mclk_in);
    endtask
    // start, also used as repeated start
    task automatic start;
        @(posedge mclk_in);
        sda_oe_out <= 1'b0;
        hp;
        scl_out <= 1'b1;
        hp;
        sda_oe_out <= 1'b1;
        hp;
        scl_out <= 1'b0;
    endtask
    task automatic stop;
        hp;
        sda_oe_out <= 1'b1;
        hp;
        scl_out <= 1'b1;
        hp;
        sda_oe_out <= 1'b0;
        hp;
    endtask
    // data only changes while the clock is low
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge mclk_in);
        sda_oe_out <= !b;
        repeat (3) @(posedge mclk_in);
        scl_out <= 1'b1;
        hp;
        r = sda_in;
        scl_out <= 1'b0;
    endtask
    // eight bits, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ak_in, output logic [7:0] q,
                        output logic ak);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            q = {q[6:0], b};
        end
        bit_io(ak_in, ak);
    endtask
endmodule // tw_host_model

// ### bench/tw_thermal_watchdog_tb_top.sv
// Bench for the thermal watchdog: register access over the bus, alert checks.
// Assumes the host model and the design share the same clock.
`timescale 1ns/10ps
module tw_thermal_watchdog_tb_top;
    logic        mclk, rst_n, conv_done, scl, host_oe, dut_oe, alert_oe, conv_en;
    logic        sda_val, alert_val;
    logic [10:0] temp;
    wire         sda = !(dut_oe | host_oe);
    int          num_errors;
    int          cmp_count;
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    tw_thermal_watchdog DUT (.mclk_in(mclk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
        .conv_done_in(conv_done), .temp_data_in(temp), .sda_out(sda_val), .sda_oe_out(dut_oe),
        .alert_out(alert_val), .alert_oe_out(alert_oe), .conv_enable_out(conv_en));
    tw_host_model HOST (.mclk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
            num_errors++;
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Pointer write, then either data bytes or a repeated start and n read bytes.
    task automatic acc(input logic [1:0] p, input logic rd, input int n, input logic [15:0] d);
        logic [7:0] q1, q2;
        logic       a;
        q2 = 8'h00;
        HOST.start;
        HOST.xfer(8'h90, 1'b1, q1, a);
        chk({15'h0000, a}, 16'h0000);
        HOST.xfer({6'h00, p}, 1'b1, q1, a);
        if (rd) begin
            HOST.start;
            HOST.xfer(8'h91, 1'b1, q1, a);
            HOST.xfer(8'hFF, n == 1, q1, a);
            if (n == 2) HOST.xfer(8'hFF, 1'b1, q2, a);
            chk({q1, q2}, d);
        end else begin
            for (int i = 0; i < n; i++) HOST.xfer(i == 0 ? d[15:8] : d[7:0], 1'b1, q1, a);
        end
        HOST.stop;
    endtask
    // One conversion, then the alert pin level is compared.
    task automatic conv(input logic [10:0] t, input logic pin);
        @(posedge mclk);
        conv_done <= 1'b1;
        temp      <= t;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (6) @(posedge mclk);
        chk({15'h0000, !alert_oe}, {15'h0000, pin});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        acc(2'h3, 1'b1, 2, 16'h5000);
        acc(2'h2, 1'b1, 2, 16'h4B00);
        acc(2'h1, 1'b1, 1, 16'h0000);
        chk({15'h0000, conv_en}, 16'h0001);
        chk({14'h0000, sda_val, alert_val}, 16'h0000);
    endtask
    task automatic t_comparator;
        conv(11'h283, 1'b1);
        conv(11'h288, 1'b0);
        acc(2'h1, 1'b1, 1, 16'h0000);
        chk({15'h0000, !alert_oe}, 16'h0000);
        conv(11'h258, 1'b0);
        conv(11'h257, 1'b1);
    endtask
    task automatic t_queue_polarity;
        acc(2'h3, 1'b0, 2, 16'h1980);
        acc(2'h3, 1'b1, 2, 16'h1980);
        acc(2'h2, 1'b0, 2, 16'h1800);
        acc(2'h1, 1'b0, 1, 16'h0C00);
        conv(11'h100, 1'b0);
        conv(11'h100, 1'b1);
        conv(11'h080, 1'b1);
        conv(11'h080, 1'b0);
        acc(2'h1, 1'b0, 1, 16'h1C00);
        for (int i = 0; i < 6; i++) conv(11'h100, i == 5);
        for (int i = 0; i < 6; i++) conv(11'h080, i < 5);
    endtask
    task automatic t_interrupt_shutdown;
        acc(2'h1, 1'b0, 1, 16'h0200);
        conv(11'h100, 1'b0);
        conv(11'h100, 1'b0);
        acc(2'h1, 1'b1, 1, 16'h0200);
        chk({15'h0000, !alert_oe}, 16'h0001);
        conv(11'h100, 1'b1);
        conv(11'h080, 1'b0);
        acc(2'h1, 1'b0, 1, 16'h0300);
        chk({15'h0000, !alert_oe}, 16'h0001);
        chk({15'h0000, conv_en}, 16'h0000);
        conv(11'h100, 1'b1);
        acc(2'h1, 1'b1, 1, 16'h0300);
        acc(2'h1, 1'b0, 1, 16'h0000);
        chk({15'h0000, conv_en}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n     = 1'b0;
        conv_done = 1'b0;
        temp      = 11'h000;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_defaults;
        t_comparator;
        t_queue_polarity;
        t_interrupt_shutdown;
        final_report;
    end
    // The tests take about 6000 cycles; ten times that means a hang.
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        final_report;
    end
endmodule // tw_thermal_watchdog_tb_top
